// ===== design/eth_cmp_defs.svh
// Constants of the Ethernet header comparator stage
`ifndef ETH_CMP_DEFS_SVH
`define ETH_CMP_DEFS_SVH

// Field byte counts, written as the count of the last byte
`define ADDR_LAST    6'h0B
`define PAIR_LAST    6'h01
`define LLC_LAST     6'h02
`define OUI_LAST     6'h02
`define ITAG_LAST    6'h03

// Tag and type values
`define CTAG_TPID    16'h8100
`define ITAG_TPID    16'h88E7
`define LEN_LIMIT    16'h0600
`define SAP_SNAP     8'hAA
`define SAP_SNAP_ALT 8'hAB
`define LLC_CTL      8'h03
`define OUI_ZERO     24'h000000
`define OUI_ALT      24'h0000F8

// Tag limits
`define MAX_TAGS     2'h2
`define PBB_MAX_TAGS 2'h1

// Comparator stage codes
`define STG_ETH1     3'h0
`define STG_ETH2     3'h1
`define STG_IP1      3'h2
`define STG_IP2      3'h3
`define STG_MPLS     3'h4
`define STG_PTP      3'h5

// Flow set layout
`define NUM_FLOWS    8
`define VID_W        12
`define VID_ZERO     12'h000
`define NO_FLOWS     8'h00

`endif

// ===== design/eth_cmp_pkg.sv
// Types of the Ethernet header comparator stage
package eth_cmp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ADDR   = 3'b001,
        ST_TYPE   = 3'b010,
        ST_TAG    = 3'b011,
        ST_LLC    = 3'b100,
        ST_OUI    = 3'b101,
        ST_ITAG   = 3'b110,
        ST_DONE   = 3'b111
    } parse_e;

    typedef struct packed {
        parse_e      st;
        logic        report;
        logic [7:0]  pos;
        logic [5:0]  cnt;
        logic [23:0] sh;
        logic [1:0]  tags;
        logic        type1;
        logic        snap;
        logic        ok;
        logic [15:0] etype;
        logic [11:0] vid;
        logic        vid_vld;
        logic [7:0]  base;
        logic [7:0]  hend;
        logic        match;
        logic        fany;
        logic [7:0]  npos;
        logic [7:0]  spos;
        logic [2:0]  nstage;
    } cmp_s;

    typedef struct packed {
        logic [7:0] hit;
    } flow_s;

endpackage

// ===== design/hdr_bus_if.sv
// Header fields passed from the parser to the flow match sets
`timescale 1ns/100ps
`default_nettype none

interface hdr_bus_if;
    logic [11:0] vid;
    logic        vid_vld;
    logic [7:0]  hit;

    modport parser (output vid, output vid_vld, input hit);
    modport flows  (input vid, input vid_vld, output hit);
endinterface

`default_nettype wire

// ===== design/eth_flow_match.sv
// Per-flow VLAN match sets of the Ethernet comparator
`timescale 1ns/100ps
`default_nettype none
`include "eth_cmp_defs.svh"

module eth_flow_match
    import eth_cmp_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Flow configuration
    input  wire logic [7:0]    flow_enable,
    input  wire logic [95:0]   flow_vid,
    input  wire logic [95:0]   flow_vid_mask,
    // Parser side
    hdr_bus_if.flows           hb
);

    flow_s st;
    flow_s nxt;
    logic [7:0] hit_w;

    // Per-flow match
    // One compare per flow; a masked-off bit is a wildcard
    genvar i;
    generate
        for (i = 0; i < `NUM_FLOWS; i = i + 1) begin : g_flow
            logic [11:0] dif;
            assign dif = (hb.vid ^ flow_vid[i*`VID_W +: `VID_W])
                       & flow_vid_mask[i*`VID_W +: `VID_W];
            assign hit_w[i] = flow_enable[i] && (dif == `VID_ZERO)
                && (hb.vid_vld
                    || flow_vid_mask[i*`VID_W +: `VID_W] == `VID_ZERO);
        end
    endgenerate

    // Next state
    always_comb begin
        nxt = st;
        nxt.hit = hit_w;
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    assign hb.hit = st.hit;

    // Disabled flows never report
    generate
        for (i = 0; i < `NUM_FLOWS; i = i + 1) begin : g_chk
            flow_off_a: assert property (
                @(posedge clk) disable iff (!rst_n)
                !flow_enable[i] |=> !hb.hit[i])
                else $error("disabled flow reported a hit");
        end
    endgenerate

endmodule

`default_nettype wire

// ===== design/eth_hdr_cmp.sv
// Ethernet/LLC/SNAP header comparator stage with next-protocol check
`timescale 1ns/100ps
`default_nettype none
`include "eth_cmp_defs.svh"

// Overview of operation
// - Two such stages per engine; FIRST_STAGE marks the fixed first.
// - Length frames accept only the LLC plus SNAP layout.
// - Type II frames carry up to two service or customer tags.
// - LLC before SNAP: both SAP bytes AA or AB, control 03.
// - SNAP is three OUI bytes then two EtherType bytes.
// - SNAP OUI must be zero or F8, fixed in hardware.
// - A tag type inside SNAP means a tag follows right after.
// - Two tags plus LLC plus SNAP is the longest header handled.
// - Backbone mode: type II, zero or one tag, then an I-tag.
// - One next-protocol check set shared by all flows.
// - Per-flow match sets report whether any flow matched.
// - The last EtherType of the header is the one checked.
// - Tags and length field checked by mask or range.
// - Three-bit field selects the stage getting the start position.
// - Five-bit field gives the frame signature start position.
// - One 16-bit global TPID matches service tags; I-tags use the fixed 88E7.
// - Backbone enable exists only in the first stage.
// - EtherType match enable acts only on type II frames.
// - When enabled, the EtherType is compared to a 16-bit value.
// - Stage codes: 0,1 Ethernet, 2,3 IP, 4 MPLS, 5 PTP/OAM.
// - Positions are bytes, first byte of the frame is zero.
// - Mask bit one compares, mask bit zero is a wildcard.
// - With mode set, values below 0600 are lengths needing LLC.
module eth_hdr_cmp
    import eth_cmp_pkg::*;
#(
    parameter bit FIRST_STAGE = 1'b1
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Frame byte stream
    input  wire logic        sof,
    input  wire logic        eof,
    input  wire logic        byte_vld,
    input  wire logic [7:0]  byte_data,
    // Start position from the engine controller
    input  wire logic [7:0]  start_pos,
    // Next-protocol configuration
    input  wire logic [2:0]  nxt_comparator,
    input  wire logic [4:0]  frame_sig_offset,
    input  wire logic [15:0] service_tag_protocol_id,
    input  wire logic        backbone_bridging_enable,
    input  wire logic        etype_match_enable,
    input  wire logic [15:0] etype_match,
    input  wire logic        ethertype_mode,
    input  wire logic [11:0] vid_match,
    input  wire logic [11:0] vid_mask,
    input  wire logic [15:0] len_min,
    input  wire logic [15:0] len_max,
    // Flow configuration
    input  wire logic [7:0]  flow_enable,
    input  wire logic [95:0] flow_vid,
    input  wire logic [95:0] flow_vid_mask,
    // Result to the engine controller
    output logic             done,
    output logic             match,
    output logic             flow_any,
    output logic [2:0]       next_stage,
    output logic [7:0]       next_pos,
    output logic [7:0]       sig_pos
);

    cmp_s        st;
    cmp_s        nxt;
    logic [23:0] nb;
    logic [15:0] v;
    logic [7:0]  cur_idx;
    logic        go;
    logic        last_pair;
    logic        pbb_on;
    logic        tpid_hit;
    logic        itag_hit;
    logic        len_hit;
    logic        vid_hit;
    logic        oui_hit;
    logic        sap_hit;
    logic        stage_ok;
    logic [7:0]  sig_exp;

    hdr_bus_if hb ();

    // Flow match sets
    eth_flow_match u_flows (
        .clk           (clk),
        .rst_n         (rst_n),
        .flow_enable   (flow_enable),
        .flow_vid      (flow_vid),
        .flow_vid_mask (flow_vid_mask),
        .hb            (hb)
    );

    assign hb.vid     = st.vid;
    assign hb.vid_vld = st.vid_vld;

    // Byte window and field decodes
    assign nb        = {st.sh[15:0], byte_data};
    assign v         = nb[15:0];
    assign cur_idx   = sof ? 8'h00 : st.pos;
    assign last_pair = (st.cnt == `PAIR_LAST);
    assign go = byte_vld && (cur_idx == start_pos)
             && (sof || st.st == ST_IDLE);
    assign pbb_on = FIRST_STAGE && backbone_bridging_enable;
    assign tpid_hit = (v == `CTAG_TPID) || (v == service_tag_protocol_id);
    assign itag_hit = pbb_on && (v == `ITAG_TPID) && !st.snap;
    // Length only when mode allows it
    assign len_hit  = ethertype_mode && (v < `LEN_LIMIT)
                   && !st.snap && !st.type1;
    assign vid_hit  = (((nb[11:0] ^ vid_match) & vid_mask) == `VID_ZERO);
    assign oui_hit  = (nb == `OUI_ZERO) || (nb == `OUI_ALT);
    assign sap_hit  = (byte_data == `SAP_SNAP)
                   || (byte_data == `SAP_SNAP_ALT);
    assign stage_ok = (nxt_comparator != `STG_ETH1)
                   && (nxt_comparator <= `STG_PTP);
    assign sig_exp  = st.base + {3'h0, frame_sig_offset};

    // Parser next state
    always_comb begin
        nxt = st;
        nxt.report = 1'b0;
        if (byte_vld) begin
            nxt.pos = cur_idx + 8'h01;
            nxt.sh  = nb;
            nxt.cnt = st.cnt + 6'h01;
        end
        if (go) begin
            nxt.st      = ST_ADDR;
            nxt.cnt     = 6'h01;
            nxt.tags    = 2'h0;
            nxt.type1   = 1'b0;
            nxt.snap    = 1'b0;
            nxt.ok      = 1'b1;
            nxt.vid_vld = 1'b0;
            nxt.base    = start_pos;
        end else if (byte_vld && sof) begin
            nxt.st = ST_IDLE;
        end else begin
            case (st.st)
                ST_IDLE: begin
                    nxt.st = ST_IDLE;
                end
                ST_ADDR: begin
                    if (byte_vld && st.cnt == `ADDR_LAST) begin
                        nxt.st  = ST_TYPE;
                        nxt.cnt = 6'h00;
                    end
                end
                ST_TYPE: begin
                    if (byte_vld && last_pair) begin
                        nxt.cnt = 6'h00;
                        if (tpid_hit) begin
                            if (st.tags == `MAX_TAGS) begin
                                nxt.ok   = 1'b0;
                                nxt.st   = ST_DONE;
                                nxt.hend = cur_idx + 8'h01;
                            end else begin
                                nxt.tags = st.tags + 2'h1;
                                nxt.st   = ST_TAG;
                            end
                        end else if (itag_hit) begin
                            // Zero or one tag before I-tag
                            if (st.tags > `PBB_MAX_TAGS) begin
                                nxt.ok = 1'b0;
                            end
                            nxt.st = ST_ITAG;
                        end else if (len_hit) begin
                            nxt.type1 = 1'b1;
                            nxt.st    = ST_LLC;
                            if (v < len_min || v > len_max) begin
                                nxt.ok = 1'b0;
                            end
                        end else begin
                            nxt.etype = v;
                            nxt.st    = ST_DONE;
                            nxt.hend  = cur_idx + 8'h01;
                            if (etype_match_enable && !st.type1
                                && v != etype_match) begin
                                nxt.ok = 1'b0;
                            end
                            if (pbb_on) begin
                                nxt.ok = 1'b0;
                            end
                        end
                    end
                end
                ST_TAG: begin
                    if (byte_vld && last_pair) begin
                        nxt.st  = ST_TYPE;
                        nxt.cnt = 6'h00;
                        if (!st.vid_vld) begin
                            nxt.vid     = nb[11:0];
                            nxt.vid_vld = 1'b1;
                        end
                        if (!vid_hit) begin
                            nxt.ok = 1'b0;
                        end
                    end
                end
                ST_LLC: begin
                    if (byte_vld) begin
                        if (st.cnt == `LLC_LAST) begin
                            nxt.st  = ST_OUI;
                            nxt.cnt = 6'h00;
                            if (byte_data != `LLC_CTL) begin
                                nxt.ok = 1'b0;
                            end
                        end else if (!sap_hit) begin
                            nxt.ok = 1'b0;
                        end
                    end
                end
                ST_OUI: begin
                    if (byte_vld && st.cnt == `OUI_LAST) begin
                        nxt.st   = ST_TYPE;
                        nxt.cnt  = 6'h00;
                        nxt.snap = 1'b1;
                        if (!oui_hit) begin
                            nxt.ok = 1'b0;
                        end
                    end
                end
                ST_ITAG: begin
                    if (byte_vld && st.cnt == `ITAG_LAST) begin
                        nxt.st   = ST_DONE;
                        nxt.hend = cur_idx + 8'h01;
                    end
                end
                ST_DONE: begin
                    nxt.st     = ST_IDLE;
                    nxt.report = 1'b1;
                    nxt.fany   = |hb.hit;
                    nxt.match  = st.ok && stage_ok && (|hb.hit);
                    nxt.npos   = st.hend;
                    nxt.spos   = sig_exp;
                    nxt.nstage = nxt_comparator;
                end
                default: begin
                    nxt.st = ST_IDLE;
                end
            endcase
            // Frame ended inside the header
            if (byte_vld && eof && nxt.st != ST_DONE
                && nxt.st != ST_IDLE) begin
                nxt.ok   = 1'b0;
                nxt.st   = ST_DONE;
                nxt.hend = cur_idx + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    // Result outputs
    assign done       = st.report;
    assign match      = st.match;
    assign flow_any   = st.fany;
    assign next_stage = st.nstage;
    assign next_pos   = st.npos;
    assign sig_pos    = st.spos;

    // Checks on the parser
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_hdr_end;
        st.st == ST_DONE;
    endsequence
    sequence s_report;
        done ##1 !done;
    endsequence

    report_pulse_a: assert property (s_hdr_end |=> s_report)
        else $error("header end not reported as one pulse");
    no_flow_a: assert property (done && !flow_any |-> !match)
        else $error("match reported without any flow");
    tag_limit_a: assert property (st.tags <= `MAX_TAGS)
        else $error("more than two tags counted");
    pbb_second_a: assert property (FIRST_STAGE || st.st != ST_ITAG)
        else $error("second stage parsed an I-tag");
    llc_sap_a: assert property (byte_vld && !sof && st.st == ST_LLC
        && st.cnt != `LLC_LAST && !sap_hit |=> !st.ok)
        else $error("bad SAP byte accepted");
    oui_fix_a: assert property (byte_vld && !sof && st.st == ST_OUI
        && st.cnt == `OUI_LAST && !oui_hit |=> !st.ok)
        else $error("bad OUI accepted");
    len_mode_a: assert property (!ethertype_mode && !sof
        && st.st == ST_TYPE |=> st.st != ST_LLC)
        else $error("length parsed with mode off");
    etype_chk_a: assert property (byte_vld && !sof && !eof
        && st.st == ST_TYPE && last_pair && !tpid_hit && !itag_hit
        && !len_hit && etype_match_enable && !st.type1
        && v != etype_match |=> st.st == ST_DONE && !st.ok)
        else $error("EtherType mismatch accepted");
    sig_pos_a: assert property (
        s_hdr_end |=> sig_pos == $past(sig_exp))
        else $error("signature position wrong");
    npos_a: assert property (
        s_hdr_end |=> next_pos == $past(st.hend))
        else $error("next position differs from header end");
    tag_vid_a: assert property (byte_vld && !sof && st.st == ST_TAG
        && last_pair && !vid_hit |=> !st.ok)
        else $error("tag pattern mismatch accepted");
    itag_end_a: assert property (byte_vld && st.st == ST_ITAG
        && !sof && st.cnt == `ITAG_LAST |=> st.st == ST_DONE)
        else $error("I-tag not four bytes long");
    eof_end_a: assert property (byte_vld && eof && !sof
        && st.st != ST_IDLE && st.st != ST_DONE |=> st.st == ST_DONE)
        else $error("frame end inside header not closed");

endmodule

`default_nettype wire

// ===== verification/frame_src.sv
// Frame byte source that stands in for the engine's data path aligner
`timescale 1ns/100ps
`default_nettype none

module frame_src (
    // Clock
    input  wire logic clk,
    // Byte stream to the comparator
    output logic       sof,
    output logic       eof,
    output logic       byte_vld,
    output logic [7:0] byte_data
);
    logic [7:0] q[$];

    // Idle stream at time zero
    initial begin
        sof = 1'b0;
        eof = 1'b0;
        byte_vld = 1'b0;
        byte_data = 8'h00;
    end

    // Queue one byte of the next frame
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask

    // Idle cycle; the data lines show the inverse of their previous value
    task automatic idle;
        @(posedge clk);
        #1;
        {sof, eof, byte_vld} = 3'b000;
        byte_data = ~byte_data;
    endtask

    // Send the queued frame, stalling gap cycles after every byte
    task automatic run(input int gap);
        int n;
        n = q.size();
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            sof = (i == 0);
            eof = (i == n - 1);
            byte_vld = 1'b1;
            byte_data = q[i];
            repeat (gap) idle();
        end
        idle();
        q.delete();
    endtask
endmodule

`default_nettype wire

// ===== verification/ethernet_snap_llc_header_comparator_test.sv
// Self-checking bench for the Ethernet header comparator stage
`timescale 1ns/100ps
`default_nettype none

module ethernet_snap_llc_header_comparator_test;
    typedef struct {
        int          nt;
        bit          sn;
        bit          st;
        logic [7:0]  sap;
        logic [7:0]  ctl;
        logic [23:0] oui;
        logic [15:0] et;
        logic        m;
        logic [7:0]  pos;
    } row_s;

    logic        clk, rst_n, sof, eof, byte_vld;
    logic [7:0]  byte_data, start_pos, flow_enable;
    logic [2:0]  nxt_comparator, next_stage;
    logic [4:0]  frame_sig_offset;
    logic [15:0] service_tag_protocol_id, etype_match, len_min, len_max;
    logic        backbone_bridging_enable, etype_match_enable;
    logic        ethertype_mode, done, match, flow_any, done2, match2;
    logic [11:0] vid_match, vid_mask;
    logic [95:0] flow_vid, flow_vid_mask;
    logic [7:0]  next_pos, sig_pos, next_pos2;
    int          n_fail = 0;
    int          compares = 0;
    int          ndone = 0;
    logic [7:0]  fq[$];
    row_s        r;

    // Frame kinds and the result each should give
    row_s rows [12] = '{
        '{0, 0, 0, 8'hAA, 8'h03, 24'h0, 16'h88F7, 1'b1, 8'h0E},
        '{1, 0, 0, 8'hAA, 8'h03, 24'h0, 16'h88F7, 1'b1, 8'h12},
        '{2, 0, 0, 8'hAA, 8'h03, 24'h0, 16'h88F7, 1'b1, 8'h16},
        '{0, 0, 0, 8'hAA, 8'h03, 24'h0, 16'h0800, 1'b0, 8'h0E},
        '{0, 1, 0, 8'hAA, 8'h03, 24'h0, 16'h0800, 1'b1, 8'h16},
        '{0, 1, 0, 8'hAB, 8'h03, 24'hF8, 16'h88F7, 1'b1, 8'h16},
        '{0, 1, 0, 8'hAA, 8'h03, 24'h1, 16'h0800, 1'b0, 8'h16},
        '{0, 1, 0, 8'hAA, 8'h04, 24'h0, 16'h0800, 1'b0, 8'h16},
        '{2, 1, 0, 8'hAA, 8'h03, 24'h0, 16'h0800, 1'b1, 8'h1E},
        '{0, 1, 1, 8'hAA, 8'h03, 24'h0, 16'h0800, 1'b1, 8'h1A},
        '{0, 0, 0, 8'hAA, 8'h03, 24'h0, 16'h0600, 1'b0, 8'h0E},
        '{0, 0, 0, 8'hAA, 8'h03, 24'h0, 16'h05FF, 1'b0, 8'h0E}
    };

    frame_src src (.clk, .sof, .eof, .byte_vld, .byte_data);

    eth_hdr_cmp #(.FIRST_STAGE(1'b1)) uut (
        .clk, .rst_n, .sof, .eof, .byte_vld, .byte_data, .start_pos,
        .nxt_comparator, .frame_sig_offset, .service_tag_protocol_id,
        .backbone_bridging_enable, .etype_match_enable, .etype_match,
        .ethertype_mode, .vid_match, .vid_mask, .len_min, .len_max,
        .flow_enable, .flow_vid, .flow_vid_mask, .done, .match,
        .flow_any, .next_stage, .next_pos, .sig_pos);

    // Second stage copy, where backbone mode must stay off
    eth_hdr_cmp #(.FIRST_STAGE(1'b0)) uut2 (
        .clk, .rst_n, .sof, .eof, .byte_vld, .byte_data, .start_pos,
        .nxt_comparator, .frame_sig_offset, .service_tag_protocol_id,
        .backbone_bridging_enable, .etype_match_enable, .etype_match,
        .ethertype_mode, .vid_match, .vid_mask, .len_min, .len_max,
        .flow_enable, .flow_vid, .flow_vid_mask, .done(done2),
        .match(match2), .flow_any(), .next_stage(),
        .next_pos(next_pos2), .sig_pos());

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Count result pulses
    always @(posedge clk) begin
        if (done === 1'b1) ndone++;
    end

    task automatic fail(input string msg);
        n_fail++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic p16(input logic [15:0] v);
        fq.push_back(v[15:8]);
        fq.push_back(v[7:0]);
    endtask

    // Assemble one frame: addresses, tags, LLC/SNAP, type, payload
    task automatic build(input row_s x);
        for (int i = 0; i < 12; i++) fq.push_back(8'h10 + 8'(i));
        if (x.nt == 2) begin
            p16(16'h8A88);
            p16(16'h0123);
        end
        if (x.nt != 0) begin
            p16(16'h8100);
            p16(16'h0123);
        end
        if (x.sn) begin
            p16(16'h002E);
            fq.push_back(x.sap);
            fq.push_back(x.sap);
            fq.push_back(x.ctl);
            p16(x.oui[23:8]);
            fq.push_back(x.oui[7:0]);
            if (x.st) begin
                p16(16'h8100);
                p16(16'h0123);
            end
        end
        p16(x.et);
        repeat (4) fq.push_back(8'h5A);
    endtask

    // Send the built frame and wait a bounded time for its result
    task automatic frame(input int gap);
        ndone = 0;
        foreach (fq[i]) src.push(fq[i]);
        src.run(gap);
        fq.delete();
        for (int k = 0; k < 12 && ndone == 0; k++) @(posedge clk);
        @(posedge clk);
        #1;
    endtask

    task automatic check(input logic em, input logic [7:0] ep,
                         input logic [7:0] es);
        compares += 2;
        if (ndone != 1) fail("result pulse count");
        if (match !== em) fail("match flag");
        if (em === 1'b1) begin
            compares += 3;
            if (next_pos !== ep) fail("next position");
            if (sig_pos !== es) fail("signature position");
            if (next_stage !== nxt_comparator) fail("next stage");
        end
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        start_pos = 8'h00;
        nxt_comparator = 3'h2;
        frame_sig_offset = 5'h07;
        service_tag_protocol_id = 16'h8A88;
        backbone_bridging_enable = 1'b0;
        etype_match_enable = 1'b1;
        etype_match = 16'h88F7;
        ethertype_mode = 1'b1;
        {vid_match, vid_mask} = 24'h0;
        len_min = 16'h0000;
        len_max = 16'h05FF;
        flow_enable = 8'h03;
        flow_vid = 96'h123000;
        flow_vid_mask = 96'hFFF000;
        repeat (4) @(posedge clk);
        #1;
        compares++;
        if ({done, match, flow_any, next_stage, next_pos, sig_pos} !== 22'h0)
            fail("outputs in reset");
        rst_n = 1'b1;
        foreach (rows[i]) begin
            build(rows[i]);
            frame(i % 3);
            check(rows[i].m, rows[i].pos, 8'h07);
        end
        for (int c = 0; c < 6; c++) begin
            nxt_comparator = 3'(c);
            build(rows[0]);
            frame(0);
            check(c != 0, 8'h0E, 8'h07);
        end
        nxt_comparator = 3'h2;
        for (int v = 0; v < 3; v++) begin
            vid_mask = (v == 1) ? 12'hFF0 : 12'hFFF;
            vid_match = (v == 0) ? 12'h123 : (v == 1) ? 12'h12F : 12'h124;
            build(rows[1]);
            frame(1);
            check(v != 2, 8'h12, 8'h07);
        end
        vid_mask = 12'h000;
        start_pos = 8'h04;
        repeat (4) fq.push_back(8'hEE);
        build(rows[0]);
        frame(0);
        check(1'b1, 8'h12, 8'h0B);
        start_pos = 8'h00;
        flow_enable = 8'h02;
        for (int t = 0; t < 2; t++) begin
            build(rows[t]);
            frame(0);
            check(t == 1, 8'h12, 8'h07);
            compares++;
            if (flow_any !== (t == 1)) fail("flow hit");
        end
        flow_enable = 8'h03;
        backbone_bridging_enable = 1'b1;
        etype_match = 16'h88E7;
        for (int t = 0; t < 2; t++) begin
            r = rows[t];
            r.et = 16'h88E7;
            build(r);
            frame(2);
            check(1'b1, 8'h12 + 8'(4 * t), 8'h07);
            compares++;
            if (match2 !== 1'b1 || next_pos2 !== 8'h0E + 8'(4 * t))
                fail("second stage parse");
        end
        backbone_bridging_enable = 1'b0;
        // Length values parsed as EtherType with the mode off
        ethertype_mode = 1'b0;
        etype_match = 16'h05FF;
        build(rows[11]);
        frame(0);
        check(1'b1, 8'h0E, 8'h07);
        // Boundary value is an EtherType with the mode on
        ethertype_mode = 1'b1;
        etype_match = 16'h0600;
        build(rows[10]);
        frame(0);
        check(1'b1, 8'h0E, 8'h07);
        // Length outside the range refuses the frame
        len_max = 16'h002D;
        build(rows[4]);
        frame(0);
        check(1'b0, 8'h16, 8'h07);
        len_max = 16'h05FF;
        etype_match = 16'h88F7;
        build(rows[0]);
        fq = fq[0:9];
        frame(0);
        check(1'b0, 8'h00, 8'h00);
        stop_test();
    end

    // Watchdog against a hung parse
    initial begin
        #200000;
        fail("watchdog expired");
        stop_test();
    end
endmodule

`default_nettype wire
